//--- include/dtc_pkg.sv
// Purpose: Shared constants and types for the dual timer/counter input control block
// Assumes: One oscillator clock, byte-wide special-function register port
// Notes: Every offset, field position, reset value and count lives here
// Overview of operation
// - Timer function adds one to the count every machine cycle while enabled.
// - A machine cycle is six oscillator periods.
// - Counter function counts falling transitions on the timer's own event pin.
// - Event pin sampled once per machine cycle; count on high sample then low.
// - New count shows in the machine cycle after the detected transition.
// - Edge detection spans two machine cycles, capping event rate at one twelfth.
// - Two-bit field picks four modes; mode 3 differs between the timers.
// - Mode register: second timer in bits 7..4, first timer in bits 3..0.
// - Mode register at address 89H, byte-written only, cleared by reset.
// - Gating set: count only while gating pin high and run bit set.
// - Gating clear: count whenever run bit set, gating pin ignored.
// - Function bit clear counts internal clock; set counts event pin.
// - Mode codes: 13-bit, 16-bit, 8-bit auto-reload, split mode 3.
// - Run bits sit at control bit 6 (second) and bit 4 (first).
// - Overflow sets flag; vector acknowledge or software write clears it.
// - Mode 0 count is high byte plus low five bits, flags on rollover.
package dtc_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [7:0] MODE_REG_ADDR = 8'h89;
	localparam logic [7:0] TCON_ADDR = 8'h88;
	localparam logic [7:0] CNT_LO_ADDR [2] = '{8'h8a, 8'h8b};
	localparam logic [7:0] CNT_HI_ADDR [2] = '{8'h8c, 8'h8d};
	// ==========================================================
	// Reset values
	localparam logic [7:0] MODE_REG_RESET = 8'h00;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [1:0] TCON_BITS_RESET = 2'h0;
	// ==========================================================
	// Mode register field layout, per timer nibble
	localparam int MODE_FIELD_W = 4;
	localparam int GATE_BIT = 3;
	localparam int FUNC_BIT = 2;
	localparam int MODE_LO_BIT = 0;
	// ==========================================================
	// Control register bit positions
	localparam int OVF1_BIT = 7;
	localparam int RUN1_BIT = 6;
	localparam int OVF0_BIT = 5;
	localparam int RUN0_BIT = 4;
	// ==========================================================
	// Timing
	localparam int OSC_PER_MC = 6;
	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_13 = 2'b00,
		MODE_16 = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} dtc_mode_t;
endpackage

//--- include/dtc_cnt_if.sv
// Purpose: Carrier between the control top and one count core
// Assumes: Single clock domain
// Notes: Strobes are one-cycle pulses
`timescale 1ns/1ps
interface dtc_cnt_if;
	dtc_pkg::dtc_mode_t mode;
	logic inc_lo;
	logic inc_hi;
	logic wr_lo;
	logic wr_hi;
	logic [7:0] wdata;
	logic [7:0] tl;
	logic [7:0] th;
	logic ovf_lo;
	logic ovf_hi;
	modport ctl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata, input tl, th, ovf_lo, ovf_hi);
	modport core (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata, output tl, th, ovf_lo, ovf_hi);
endinterface

//--- src/dtc_timer_core.sv
// Purpose: One timer's count bytes and per-mode count structure
// Assumes: Increment strobes already qualified by run, gating and source
// Notes: Software byte writes win over a count in the same cycle
`timescale 1ns/1ps
module dtc_timer_core #(
	parameter bit IS_FIRST = 1'b1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Control side
	dtc_cnt_if.core cnt
);
	logic [7:0] tl_q, tl_d, th_q, th_d;
	logic [12:0] c13;
	logic [15:0] c16;
	logic ovf_lo, ovf_hi;

	// ==========================================================
	// Next count per mode
	always_comb begin
		tl_d = tl_q;
		th_d = th_q;
		ovf_lo = 1'b0;
		ovf_hi = 1'b0;
		c13 = {th_q, tl_q[4:0]} + 13'h0001;
		c16 = {th_q, tl_q} + 16'h0001;
		if (cnt.inc_lo) begin
			unique case (cnt.mode)
				dtc_pkg::MODE_13: begin
					// Upper three low-byte bits are left alone
					th_d = c13[12:5];
					tl_d[4:0] = c13[4:0];
					ovf_lo = &{th_q, tl_q[4:0]};
				end
				dtc_pkg::MODE_16: begin
					{th_d, tl_d} = c16;
					ovf_lo = &{th_q, tl_q};
				end
				dtc_pkg::MODE_RELOAD: begin
					if (&tl_q) begin
						tl_d = th_q;
						ovf_lo = 1'b1;
					end else begin
						tl_d = tl_q + 8'h01;
					end
				end
				dtc_pkg::MODE_SPLIT: begin
					// Second timer never gets a strobe here
					if (IS_FIRST) begin
						tl_d = tl_q + 8'h01;
						ovf_lo = &tl_q;
					end
				end
			endcase
		end
		// High byte as separate machine-cycle timer
		if (cnt.inc_hi) begin
			th_d = th_q + 8'h01;
			ovf_hi = &th_q;
		end
		if (cnt.wr_lo) begin
			tl_d = cnt.wdata;
		end
		if (cnt.wr_hi) begin
			th_d = cnt.wdata;
		end
	end

	// Count bytes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tl_q <= dtc_pkg::CNT_RESET;
			th_q <= dtc_pkg::CNT_RESET;
		end else begin
			tl_q <= tl_d;
			th_q <= th_d;
		end
	end

	assign cnt.tl = tl_q;
	assign cnt.th = th_q;
	assign cnt.ovf_lo = ovf_lo;
	assign cnt.ovf_hi = ovf_hi;

	// ==========================================================
	// Checks
	a_hold_idle: assert property (@(posedge clk_in) disable iff (rst_in)
		(!cnt.inc_lo && !cnt.inc_hi && !cnt.wr_lo && !cnt.wr_hi) |=> $stable({tl_q, th_q}))
		else $error("count moved without strobe");
	a_mode0_roll: assert property (@(posedge clk_in) disable iff (rst_in)
		(cnt.inc_lo && cnt.mode == dtc_pkg::MODE_13 && th_q == 8'hff && tl_q[4:0] == 5'h1f
		&& !cnt.wr_lo && !cnt.wr_hi && !cnt.inc_hi) |-> ovf_lo ##1 (th_q == 8'h00 && tl_q[4:0] == 5'h00))
		else $error("13-bit rollover wrong");
	a_reload_load: assert property (@(posedge clk_in) disable iff (rst_in)
		(cnt.inc_lo && cnt.mode == dtc_pkg::MODE_RELOAD && tl_q == 8'hff && !cnt.wr_lo && !cnt.wr_hi)
		|=> (tl_q == $past(th_q) && th_q == $past(th_q)))
		else $error("auto-reload wrong");
endmodule

//--- src/dtc_top.sv
// Purpose: Input selection, gating and count enable for two timer/counters
// Assumes: Oscillator is mclk_in; pins synchronous to it; byte SFR port
// Notes: Register reads appear on the data output one cycle after the address
`timescale 1ns/1ps
module dtc_top #(
	parameter int OSC_PER_MC = dtc_pkg::OSC_PER_MC
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Special-function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Event and gating pins
	input wire logic first_event_input_in,
	input wire logic second_event_input_in,
	input wire logic first_external_gating_pin_in,
	input wire logic second_external_gating_pin_in,
	// Interrupt vector acknowledges
	input wire logic first_vector_ack_in,
	input wire logic second_vector_ack_in,
	// Overflow flags
	output logic first_overflow_flag_out,
	output logic second_overflow_flag_out
);
	localparam int DW = $clog2(OSC_PER_MC);
	localparam logic [DW-1:0] MC_LAST = DW'(OSC_PER_MC - 1);

	logic [7:0] mode_reg_q, mode_reg_d;
	logic [1:0] run_q, run_d, flag_q, flag_d;
	logic [DW-1:0] div_q, div_d;
	logic [1:0] ev_prev_q, ev_prev_d, fall_q, fall_d;
	logic [7:0] rdata_q, rdata_d;
	logic [1:0] ev_pin, gate_pin, ack;
	logic [1:0] en, inc_lo, ovf_lo, ovf_hi, ovf_ev;
	logic [7:0] cnt_lo [2];
	logic [7:0] cnt_hi [2];
	logic tick, split, th0_inc;

	assign ev_pin = {second_event_input_in, first_event_input_in};
	assign gate_pin = {second_external_gating_pin_in, first_external_gating_pin_in};
	assign ack = {second_vector_ack_in, first_vector_ack_in};

	// ==========================================================
	// Machine cycle: one tick per six oscillator periods
	assign tick = (div_q == MC_LAST);

	// First timer in mode 3 borrows the second run bit and flag
	assign split = (mode_reg_q[dtc_pkg::MODE_LO_BIT +: 2] == dtc_pkg::MODE_SPLIT);
	assign th0_inc = tick & run_q[1] & split;
	assign ovf_ev[0] = ovf_lo[0];
	assign ovf_ev[1] = split ? ovf_hi[0] : ovf_lo[1];

	// ==========================================================
	// Per-timer source selection, gating and count core
	generate
		for (genvar i = 0; i < 2; i++) begin : g_tmr
			localparam int B = i * dtc_pkg::MODE_FIELD_W;
			dtc_pkg::dtc_mode_t mode;
			logic gate, func;
			dtc_cnt_if cif();

			// Field decode, second timer in the upper nibble
			assign mode = dtc_pkg::dtc_mode_t'(mode_reg_q[B + dtc_pkg::MODE_LO_BIT +: 2]);
			assign gate = mode_reg_q[B + dtc_pkg::GATE_BIT];
			assign func = mode_reg_q[B + dtc_pkg::FUNC_BIT];

			// Gated or free run; second timer in mode 3 is stopped
			assign en[i] = run_q[i] & (~gate | gate_pin[i])
				& ~(i == 1 && mode == dtc_pkg::MODE_SPLIT);
			// Machine cycles or registered falling edge
			assign inc_lo[i] = tick & en[i] & (func ? fall_q[i] : 1'b1);

			assign cif.mode = mode;
			assign cif.inc_lo = inc_lo[i];
			assign cif.inc_hi = (i == 0) ? th0_inc : 1'b0;
			assign cif.wr_lo = sfr_wr_in && (sfr_addr_in == dtc_pkg::CNT_LO_ADDR[i]);
			assign cif.wr_hi = sfr_wr_in && (sfr_addr_in == dtc_pkg::CNT_HI_ADDR[i]);
			assign cif.wdata = sfr_wdata_in;
			assign cnt_lo[i] = cif.tl;
			assign cnt_hi[i] = cif.th;
			assign ovf_lo[i] = cif.ovf_lo;
			assign ovf_hi[i] = cif.ovf_hi;

			dtc_timer_core #(
				.IS_FIRST(i == 0)
			) u_core (
				.clk_in(mclk_in),
				.rst_in(rst_in),
				.cnt(cif.core)
			);

			// Checks per timer
			a_gate_blocks: assert property (@(posedge mclk_in) disable iff (rst_in)
				(gate && !gate_pin[i]) |-> !inc_lo[i])
				else $error("gated timer counted with pin low");
			a_run_free: assert property (@(posedge mclk_in) disable iff (rst_in)
				(tick && !gate && run_q[i] && !func && !(i == 1 && mode == dtc_pkg::MODE_SPLIT))
				|-> inc_lo[i])
				else $error("ungated timer missed a machine cycle");
			a_timer_step: assert property (@(posedge mclk_in) disable iff (rst_in)
				(inc_lo[i] && !func && mode == dtc_pkg::MODE_16 && !sfr_wr_in)
				|=> {cnt_hi[i], cnt_lo[i]} == $past({cnt_hi[i], cnt_lo[i]}) + 16'h0001)
				else $error("timer did not step by one");
			a_event_rate: assert property (@(posedge mclk_in) disable iff (rst_in)
				(inc_lo[i] && func) |=> (!inc_lo[i]) [*8] ##1 (!inc_lo[i]) [*3])
				else $error("event counted faster than one per two cycles");
			a_edge_sample: assert property (@(posedge mclk_in) disable iff (rst_in)
				(tick && !(ev_prev_q[i] && !ev_pin[i])) |=> !fall_q[i])
				else $error("edge registered without high-low samples");
			a_edge_count: assert property (@(posedge mclk_in) disable iff (rst_in)
				(tick && func && ev_prev_q[i] && !ev_pin[i]) ##1 (!tick) [*5]
				##1 (tick && en[i] && func) |-> inc_lo[i])
				else $error("detected edge not counted next machine cycle");
			a_flag_set: assert property (@(posedge mclk_in) disable iff (rst_in)
				ovf_ev[i] |=> flag_q[i])
				else $error("overflow did not set flag");
			c_event_count: cover property (@(posedge mclk_in) disable iff (rst_in)
				inc_lo[i] && func);
			c_overflow: cover property (@(posedge mclk_in) disable iff (rst_in)
				ovf_ev[i] && ack[i]);
		end
	endgenerate

	// ==========================================================
	// Next-state for control registers, sampling and read data
	always_comb begin
		mode_reg_d = mode_reg_q;
		run_d = run_q;
		flag_d = flag_q;
		ev_prev_d = ev_prev_q;
		fall_d = fall_q;
		div_d = tick ? '0 : div_q + DW'(1);
		// One sample per machine cycle, edge held for the next one
		if (tick) begin
			ev_prev_d = ev_pin;
			fall_d = ev_prev_q & ~ev_pin;
		end
		if (sfr_wr_in) begin
			if (sfr_addr_in == dtc_pkg::MODE_REG_ADDR) begin
				mode_reg_d = sfr_wdata_in;
			end
			if (sfr_addr_in == dtc_pkg::TCON_ADDR) begin
				run_d = {sfr_wdata_in[dtc_pkg::RUN1_BIT], sfr_wdata_in[dtc_pkg::RUN0_BIT]};
				flag_d = {sfr_wdata_in[dtc_pkg::OVF1_BIT], sfr_wdata_in[dtc_pkg::OVF0_BIT]};
			end
		end
		// Clear by vector, but an overflow in the same cycle wins
		flag_d = (flag_d & ~ack) | ovf_ev;
		// Read mux; unmapped addresses read zero
		rdata_d = 8'h00;
		if (sfr_addr_in == dtc_pkg::MODE_REG_ADDR) begin
			rdata_d = mode_reg_q;
		end
		if (sfr_addr_in == dtc_pkg::TCON_ADDR) begin
			rdata_d[dtc_pkg::OVF1_BIT] = flag_q[1];
			rdata_d[dtc_pkg::RUN1_BIT] = run_q[1];
			rdata_d[dtc_pkg::OVF0_BIT] = flag_q[0];
			rdata_d[dtc_pkg::RUN0_BIT] = run_q[0];
		end
		for (int k = 0; k < 2; k++) begin
			if (sfr_addr_in == dtc_pkg::CNT_LO_ADDR[k]) begin
				rdata_d = cnt_lo[k];
			end
			if (sfr_addr_in == dtc_pkg::CNT_HI_ADDR[k]) begin
				rdata_d = cnt_hi[k];
			end
		end
	end

	// Registers; mode register clears on any reset
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mode_reg_q <= dtc_pkg::MODE_REG_RESET;
			run_q <= dtc_pkg::TCON_BITS_RESET;
			flag_q <= dtc_pkg::TCON_BITS_RESET;
			div_q <= '0;
			ev_prev_q <= 2'h0;
			fall_q <= 2'h0;
			rdata_q <= 8'h00;
		end else begin
			mode_reg_q <= mode_reg_d;
			run_q <= run_d;
			flag_q <= flag_d;
			div_q <= div_d;
			ev_prev_q <= ev_prev_d;
			fall_q <= fall_d;
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign first_overflow_flag_out = flag_q[0];
	assign second_overflow_flag_out = flag_q[1];

	// ==========================================================
	// Global checks
	a_tick_period: assert property (@(posedge mclk_in) disable iff (rst_in)
		tick |=> (!tick) [*5] ##1 tick)
		else $error("machine cycle is not six clocks");
	a_mode_reset: assert property (@(posedge mclk_in)
		rst_in |=> (mode_reg_q == dtc_pkg::MODE_REG_RESET && run_q == 2'h0))
		else $error("mode register not cleared by reset");
	a_mode_read: assert property (@(posedge mclk_in) disable iff (rst_in)
		(sfr_addr_in == dtc_pkg::MODE_REG_ADDR) |=> sfr_rdata_out == $past(mode_reg_q))
		else $error("mode register read wrong");
	a_split_stop: assert property (@(posedge mclk_in) disable iff (rst_in)
		(mode_reg_q[dtc_pkg::MODE_FIELD_W + dtc_pkg::MODE_LO_BIT +: 2] == dtc_pkg::MODE_SPLIT)
		|-> !inc_lo[1])
		else $error("second timer ran in mode 3");
	c_split_hi: cover property (@(posedge mclk_in) disable iff (rst_in)
		th0_inc && ovf_hi[0]);
endmodule

//--- tb/dtc_pin_model.sv
// Purpose: Far-side model of the event and gating pins of both timers
// Assumes: Pins synchronous to the oscillator clock, changed just after a rising edge
// Notes: Event pins idle high so the first low of a burst is a real falling edge
`timescale 1ns/1ps
module dtc_pin_model (
	// Clock
	input wire logic clk_in,
	// Pins toward the device
	output logic first_event_out,
	output logic second_event_out,
	output logic first_gating_out,
	output logic second_gating_out
);
	// ==========================================
	// Pin state
	logic [1:0] ev_q = 2'b11;
	logic [1:0] gate_q = 2'b00;
	assign first_event_out = ev_q[0];
	assign second_event_out = ev_q[1];
	assign first_gating_out = gate_q[0];
	assign second_gating_out = gate_q[1];
	// Gating level change, one edge after the call
	task set_gate(input int sel, input logic v);
		@(posedge clk_in);
		gate_q[sel] <= v;
	endtask
	// Falling-edge bursts; levels shorter than a machine cycle could be missed
	task burst(input int sel, input int n, input int lo_len, input int hi_len);
		repeat (n) begin
			@(posedge clk_in);
			ev_q[sel] <= 1'b0;
			repeat (lo_len) @(posedge clk_in);
			ev_q[sel] <= 1'b1;
			repeat (hi_len - 1) @(posedge clk_in);
		end
	endtask
endmodule

//--- tb/tb_dual_timer_counter_input_control.sv
// Purpose: Self-checking bench for the dual timer/counter input control
// Assumes: Six oscillator periods per machine cycle, byte register port
// Notes: Count rates are measured as differences over exact 60-cycle windows
`timescale 1ns/1ps
module tb_dual_timer_counter_input_control;
	// ==========================================
	// Signals
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [1:0] ev;
	logic [1:0] gate;
	logic [1:0] ack = 2'b00;
	logic [1:0] flag;
	logic [31:0] rng = 32'h6d99;
	int n_fail = 0;
	int tests_run = 0;
	localparam logic [7:0] ADDRS [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e};
	// Free-running oscillator
	always #5 mclk_in = ~mclk_in;
	// ==========================================
	// Device and pin model
	dtc_top #(.OSC_PER_MC(6)) DUT (.mclk_in(mclk_in), .rst_in(rst_in),
		.sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_wdata_in(sfr_wdata),
		.sfr_rdata_out(sfr_rdata), .first_event_input_in(ev[0]),
		.second_event_input_in(ev[1]), .first_external_gating_pin_in(gate[0]),
		.second_external_gating_pin_in(gate[1]), .first_vector_ack_in(ack[0]),
		.second_vector_ack_in(ack[1]), .first_overflow_flag_out(flag[0]),
		.second_overflow_flag_out(flag[1]));
	dtc_pin_model pins (.clk_in(mclk_in), .first_event_out(ev[0]), .second_event_out(ev[1]),
		.first_gating_out(gate[0]), .second_gating_out(gate[1]));
	// ==========================================
	// Expectation helpers
	function automatic logic [31:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	function automatic logic [7:0] mode_byte(input int t, input logic [3:0] nib);
		return (t != 0) ? {nib, 4'h0} : {4'h0, nib};
	endfunction
	function automatic logic [7:0] run_byte(input int t);
		return 8'h01 << ((t != 0) ? dtc_pkg::RUN1_BIT : dtc_pkg::RUN0_BIT);
	endfunction
	function automatic logic [7:0] ticks(input int cyc);
		return 8'(cyc / dtc_pkg::OSC_PER_MC);
	endfunction
	// Thirteen-bit count; top three low-byte bits left alone
	function automatic logic [15:0] m0_after(input logic [7:0] hi, input logic [7:0] lo, input int n);
		logic [12:0] c;
		c = {hi, lo[4:0]} + 13'(n);
		return {c[12:5], lo[7:5], c[4:0]};
	endfunction
	function automatic logic [7:0] reload_after(input logic [7:0] hi, input logic [7:0] lo, input int n);
		for (int i = 0; i < n; i++) lo = (lo == 8'hff) ? hi : lo + 8'h01;
		return lo;
	endfunction
	// ==========================================
	// Bus and check tasks
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		sfr_addr <= a;
		sfr_wr <= 1'b1;
		sfr_wdata <= d;
		@(posedge mclk_in);
		sfr_wr <= 1'b0;
	endtask
	// Registered read: data settles one edge after the address
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		sfr_addr <= a;
		@(posedge mclk_in);
		#1;
		d = sfr_rdata;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	// Sample edges exactly cyc apart, so the tick phase never matters
	task delta(input logic [7:0] a, input int cyc, output logic [7:0] dv);
		logic [7:0] v0;
		logic [7:0] v1;
		rd(a, v0);
		repeat (cyc - 2) @(posedge mclk_in);
		rd(a, v1);
		dv = v1 - v0;
	endtask
	task burst_count(input int t, input int k, input int lo_l, input int hi_l, output logic [7:0] dv);
		logic [7:0] v0;
		logic [7:0] v1;
		rd(8'h8a + 8'(t), v0);
		pins.burst(t, k, lo_l, hi_l);
		repeat (18) @(posedge mclk_in);
		rd(8'h8a + 8'(t), v1);
		dv = v1 - v0;
	endtask
	// Gate pin open for exactly 60 edges
	task gated_run(input int t);
		pins.set_gate(t, 1'b1);
		repeat (59) @(posedge mclk_in);
		pins.set_gate(t, 1'b0);
		repeat (12) @(posedge mclk_in);
		#1;
	endtask
	task pulse_ack(input int t);
		@(posedge mclk_in);
		ack[t] <= 1'b1;
		@(posedge mclk_in);
		ack[t] <= 1'b0;
		#1;
	endtask
	task complete_run();
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] m;
		logic [15:0] e;
		int k;
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(ADDRS[i], v);
			chk(v, 8'h00);
		end
		// Whole-byte mode writes; an unmapped write must not disturb them
		repeat (4) begin
			m = 8'(next_rand());
			wr(8'h89, m);
			wr(8'h8f, ~m);
			rd(8'h89, v);
			chk(v, m);
		end
		wr(8'h89, 8'h00);
		for (int t = 0; t < 2; t++) begin
			wr(8'h89, mode_byte(t, 4'b0001));
			wr(8'h88, run_byte(t));
			delta(8'h8a + 8'(t), 60, v);
			chk(v, ticks(60));
			wr(8'h88, 8'h00);
			delta(8'h8a + 8'(t), 60, v);
			chk(v, 8'h00);
			wr(8'h89, mode_byte(t, 4'b1001));
			wr(8'h88, run_byte(t));
			delta(8'h8a + 8'(t), 60, v);
			chk(v, 8'h00);
			pins.set_gate(t, 1'b1);
			delta(8'h8a + 8'(t), 60, v);
			chk(v, ticks(60));
			pins.set_gate(t, 1'b0);
			wr(8'h89, mode_byte(t, 4'b0101));
			delta(8'h8a + 8'(t), 60, v);
			chk(v, 8'h00);
			k = 1 + int'(next_rand() % 10);
			burst_count(t, k, 6 + int'(next_rand() % 8), 6 + int'(next_rand() % 8), v);
			chk(v, 8'(k));
			burst_count(t, 10, 6, 6, v);
			chk(v, 8'h0a);
			// Thirteen-bit rollover, started and stopped by the gating pin
			wr(8'h89, mode_byte(t, 4'b1000));
			wr(8'h8c + 8'(t), 8'hff);
			wr(8'h8a + 8'(t), 8'hfe);
			gated_run(t);
			e = m0_after(8'hff, 8'hfe, 10);
			chk({7'h00, flag[t]}, 8'h01);
			rd(8'h8a + 8'(t), v);
			chk(v, e[7:0]);
			rd(8'h8c + 8'(t), v);
			chk(v, e[15:8]);
			pulse_ack(t);
			chk({7'h00, flag[t]}, 8'h00);
			wr(8'h88, 8'h00);
		end
		// Eight-bit auto-reload on the first timer
		wr(8'h89, 8'h0a);
		wr(8'h8c, 8'hf0);
		wr(8'h8a, 8'hfe);
		wr(8'h88, run_byte(0));
		gated_run(0);
		rd(8'h8a, v);
		chk(v, reload_after(8'hf0, 8'hfe, 10));
		rd(8'h8c, v);
		chk(v, 8'hf0);
		chk({7'h00, flag[0]}, 8'h01);
		wr(8'h88, 8'h00);
		#1;
		chk({7'h00, flag[0]}, 8'h00);
		// Second timer in mode 3 holds its count
		wr(8'h89, 8'h30);
		wr(8'h88, run_byte(1));
		delta(8'h8b, 60, v);
		chk(v, 8'h00);
		complete_run();
	end
	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (40000) @(posedge mclk_in);
		n_fail++;
		complete_run();
	end
endmodule
